// >>> design/bitblt_regs.svh
// constants for the block-transfer shift, mask and logic front end
// assumes the data port bit 0 is the leftmost pixel of a word
`ifndef BITBLT_REGS_SVH
`define BITBLT_REGS_SVH

`define CTL_WIDTH 13
`define FUNC_WIDTH 4
`define CTL_SWAP_BIT 12
`define CTL_SHIFT_HI 11
`define CTL_SHIFT_LO 8
`define CTL_LEFT_HI 7
`define CTL_LEFT_LO 4
`define CTL_RIGHT_HI 3
`define CTL_RIGHT_LO 0
`define CTL_RESET 13'h0000
`define FUNC_RESET 4'h0
`define WORD_RESET 16'h0000

`endif

// >>> design/bitblt_pkg.sv
// types shared by the block-transfer front end
// assumes a 16-bit data port
package bitblt_pkg;
  typedef logic [15:0] word_t;
  typedef logic [3:0] code_t;
  typedef enum logic {
    STEER_DEST = 1'b0,
    STEER_SRC = 1'b1
  } steer_t;
endpackage

// >>> design/bitblt_shift_mask_logic.sv
// block-transfer front end: control and function registers, input latches,
// barrel shifter and masked logic unit
// assumes phases, strobes and data are synchronous levels sampled on ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "bitblt_regs.svh"

module bitblt_shift_mask_logic
  import bitblt_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,                 // 250 MHz system clock
  input wire logic nrst,                    // async reset, active low
  input wire logic [15:0] data_in,          // data port
  input wire logic control_load_strobe_n,   // control word load, active low
  input wire logic function_load_strobe_n,  // function word load, active low
  input wire logic input_latch_strobe_n,    // master latch enable, active low
  input wire logic source_dest_steer,       // 1 source slave, 0 destination slave
  input wire logic phase_one_clock,         // first phase level
  input wire logic phase_two_clock,         // second phase level
  input wire logic line_draw_sel,           // 1 line draw, 0 block transfer
  input wire logic left_edge_mask_apply,    // apply left mask
  input wire logic right_edge_mask_apply,   // apply right mask
  input wire logic [15:0] fifo_word,        // aligned source word from fifo
  output logic [15:0] shift_word,           // barrel shifter result, to fifo
  output logic [15:0] logic_word            // masked logic result
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 16) begin : g_bad_width
    $error("data width must be 16");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // left mask decode
  function automatic word_t left_mask(input code_t n);
    left_mask = ~((16'h0001 << n) - 16'h0001);
  endfunction

  function automatic word_t right_mask(input code_t n);
    logic [16:0] w;
    w = (17'h00002 << n) - 17'h00001;
    right_mask = w[15:0];
  endfunction

  // join upper high bits with lower low bits
  function automatic word_t barrel(input word_t upper, input word_t lower, input code_t i);
    logic [31:0] w;
    w = {lower, upper} >> i;
    barrel = w[15:0];
  endfunction

  function automatic word_t bitop(input code_t f, input word_t s, input word_t d);
    bitop = ({16{f[3]}} & ~s & ~d) | ({16{f[2]}} & ~s & d)
          | ({16{f[1]}} & s & ~d) | ({16{f[0]}} & s & d);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [12:0] blit_control_ff;
  code_t logic_function_select_ff;
  word_t input_latch_ff;
  word_t src_slave_ff;
  word_t dst_slave_ff;
  word_t shifter_pipe_latch_ff;
  logic pending_ff;
  logic ph1_q_ff;
  logic ph2_q_ff;
  logic ctl_q_ff;
  logic fn_q_ff;
  word_t shift_word_ff;
  word_t logic_word_ff;

  // ----------------------------------------------------------------
  // edge detection and decode
  // ----------------------------------------------------------------
  // inputs are synchronous, so a registered copy is enough for edges
  wire ph1_rise = phase_one_clock & ~ph1_q_ff;
  wire ph2_fall = ~phase_two_clock & ph2_q_ff;
  wire ctl_rise = control_load_strobe_n & ~ctl_q_ff;
  wire fn_rise = function_load_strobe_n & ~fn_q_ff;

  wire swap_bit = blit_control_ff[`CTL_SWAP_BIT];
  wire code_t shift_count = blit_control_ff[`CTL_SHIFT_HI:`CTL_SHIFT_LO];
  wire code_t left_edge_mask_code = blit_control_ff[`CTL_LEFT_HI:`CTL_LEFT_LO];
  wire code_t right_edge_mask_code = blit_control_ff[`CTL_RIGHT_HI:`CTL_RIGHT_LO];

  wire ctl_load = ctl_rise & ~line_draw_sel;
  wire fn_load = fn_rise;
  wire master_load = ph2_fall & ~input_latch_strobe_n;

  // source and destination words kept apart
  wire to_src = ph1_rise & pending_ff & (steer_t'(source_dest_steer) == STEER_SRC);
  wire to_dst = ph1_rise & pending_ff & (steer_t'(source_dest_steer) == STEER_DEST);

  // swap high: source slave is upper word
  wire word_t upper_word = swap_bit ? src_slave_ff : shifter_pipe_latch_ff;
  wire word_t lower_word = swap_bit ? shifter_pipe_latch_ff : src_slave_ff;
  wire word_t nxt_shift_word = barrel(upper_word, lower_word, shift_count);

  wire word_t lmask = left_edge_mask_apply ? left_mask(left_edge_mask_code) : 16'hFFFF;
  wire word_t rmask = right_edge_mask_apply ? right_mask(right_edge_mask_code) : 16'hFFFF;
  wire word_t enable_mask = lmask & rmask;

  wire word_t raw_result = bitop(logic_function_select_ff, fifo_word, dst_slave_ff);
  wire word_t nxt_logic_word = (raw_result & enable_mask) | (dst_slave_ff & ~enable_mask);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ph1_q_ff <= 1'b0;
      ph2_q_ff <= 1'b0;
      ctl_q_ff <= 1'b1;
      fn_q_ff <= 1'b1;
    end else begin
      ph1_q_ff <= phase_one_clock;
      ph2_q_ff <= phase_two_clock;
      ctl_q_ff <= control_load_strobe_n;
      fn_q_ff <= function_load_strobe_n;
    end
  end

  // reset value carries no meaning; controller loads before use
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      blit_control_ff <= `CTL_RESET;
      logic_function_select_ff <= `FUNC_RESET;
    end else begin
      if (ctl_load) begin
        blit_control_ff <= data_in[`CTL_WIDTH-1:0];
      end
      if (fn_load) begin
        logic_function_select_ff <= data_in[`FUNC_WIDTH-1:0];
      end
    end
  end

  // a capture on the same cycle as a phase-one rise waits for the next rise
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      input_latch_ff <= `WORD_RESET;
      pending_ff <= 1'b0;
    end else begin
      if (master_load) begin
        input_latch_ff <= data_in;
      end
      pending_ff <= master_load | (pending_ff & ~ph1_rise);
    end
  end

  // pipeline takes old source slave on every rise
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      src_slave_ff <= `WORD_RESET;
      dst_slave_ff <= `WORD_RESET;
      shifter_pipe_latch_ff <= `WORD_RESET;
    end else begin
      if (ph1_rise) begin
        shifter_pipe_latch_ff <= src_slave_ff;
      end
      if (to_src) begin
        src_slave_ff <= input_latch_ff;
      end
      if (to_dst) begin
        dst_slave_ff <= input_latch_ff;
      end
    end
  end

  // logic result holds while line drawing, that path is not built here
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      shift_word_ff <= `WORD_RESET;
      logic_word_ff <= `WORD_RESET;
    end else begin
      shift_word_ff <= nxt_shift_word;
      if (!line_draw_sel) begin
        logic_word_ff <= nxt_logic_word;
      end
    end
  end

  assign shift_word = shift_word_ff;
  assign logic_word = logic_word_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence ctl_write_s;
    ctl_rise && !line_draw_sel;
  endsequence

  sequence master_cap_s;
    ph2_fall && !input_latch_strobe_n;
  endsequence

  sequence steer_src_s;
    ph1_rise && pending_ff && source_dest_steer;
  endsequence

  // a capture is steered by the first phase-one rise after it
  sequence steer_dst_s;
    ph1_rise && pending_ff && !source_dest_steer;
  endsequence

  sequence lone_rise_s;
    ph1_rise && !pending_ff;
  endsequence

  sequence open_blit_s;
    !line_draw_sel && !left_edge_mask_apply && !right_edge_mask_apply;
  endsequence

  AST_CTL_LOAD: assert property (ctl_write_s |=> blit_control_ff == $past(data_in[12:0]))
    else $error("control word not captured");

  AST_CTL_FROZEN: assert property (line_draw_sel |=> $stable(blit_control_ff))
    else $error("control word changed in line-draw mode");

  AST_FN_LOAD: assert property (fn_rise |=> logic_function_select_ff == $past(data_in[3:0]))
    else $error("function word not captured");

  AST_MASTER_CAP: assert property (master_cap_s |=> input_latch_ff == $past(data_in))
    else $error("master latch missed capture");

  AST_STEER_SRC: assert property (master_cap_s ##1 steer_src_s
      |=> src_slave_ff == $past(input_latch_ff) && $stable(dst_slave_ff))
    else $error("source slave not loaded from master");

  AST_STEER_DST: assert property (master_cap_s ##1 steer_dst_s
      |=> dst_slave_ff == $past(input_latch_ff) && $stable(src_slave_ff))
    else $error("destination slave not loaded from master");

  AST_NO_STEER: assert property (lone_rise_s
      |=> $stable(src_slave_ff) && $stable(dst_slave_ff))
    else $error("slave changed without a capture");

  AST_PENDING_CLR: assert property (ph1_rise && !master_load |=> !pending_ff)
    else $error("capture left pending after phase-one rise");

  AST_MASTER_HOLD: assert property (!master_load |=> $stable(input_latch_ff))
    else $error("master latch changed without capture");

  AST_PIPE: assert property (ph1_rise |=> shifter_pipe_latch_ff == $past(src_slave_ff))
    else $error("pipeline latch not advanced");

  // hold checks tie each register to its own load condition
  AST_PIPE_HOLD: assert property (!ph1_rise |=> $stable(shifter_pipe_latch_ff))
    else $error("pipeline latch moved without phase-one rise");

  AST_CTL_HOLD: assert property (!ctl_load |=> $stable(blit_control_ff))
    else $error("control word changed without a load");

  AST_FN_HOLD: assert property (!fn_rise |=> $stable(logic_function_select_ff))
    else $error("function word changed without a load");

  // shift checks pick table rows at both ends and the swap
  AST_NO_SHIFT: assert property (shift_count == 4'h0 && !swap_bit
      |=> shift_word == $past(shifter_pipe_latch_ff))
    else $error("unshifted output is not the upper word");

  AST_SWAP_ZERO: assert property (shift_count == 4'h0 && swap_bit
      |=> shift_word == $past(src_slave_ff))
    else $error("swapped unshifted output is not the source slave");

  AST_SHIFT_ONE: assert property (shift_count == 4'h1 && !swap_bit
      |=> shift_word == {$past(src_slave_ff[0]), $past(shifter_pipe_latch_ff[15:1])})
    else $error("one-bit shift did not take the lower word bit zero");

  AST_SHIFT_MAX: assert property (shift_count == 4'hF && !swap_bit
      |=> shift_word == {$past(src_slave_ff[14:0]), $past(shifter_pipe_latch_ff[15])})
    else $error("fifteen-bit shift gave a wrong word");

  AST_PRESERVE: assert property (!line_draw_sel
      |=> ((logic_word ^ $past(dst_slave_ff)) & ~$past(enable_mask)) == 16'h0000)
    else $error("masked destination bit changed");

  AST_ALL_ONES: assert property (!line_draw_sel && !left_edge_mask_apply
      && !right_edge_mask_apply && logic_function_select_ff == 4'hF
      |=> logic_word == 16'hFFFF)
    else $error("function fifteen did not give ones");

  AST_ALL_ZERO: assert property (open_blit_s ##0 logic_function_select_ff == 4'h0
      |=> logic_word == 16'h0000)
    else $error("function zero did not give zeros");

  AST_COPY_SRC: assert property (open_blit_s ##0 logic_function_select_ff == 4'h3
      |=> logic_word == $past(fifo_word))
    else $error("function three did not pass the fifo word");

  AST_LD_HOLD: assert property (line_draw_sel |=> $stable(logic_word))
    else $error("logic result moved in line-draw mode");

  // mask checks use codes that the bench walks through
  AST_RIGHT_ONLY: assert property (!line_draw_sel && right_edge_mask_apply
      && !left_edge_mask_apply && right_edge_mask_code == 4'h0
      && logic_function_select_ff == 4'hF
      |=> logic_word == ($past(dst_slave_ff) | 16'h0001))
    else $error("right code zero did not enable bit zero only");

  AST_RIGHT_FULL: assert property (!line_draw_sel && right_edge_mask_apply
      && !left_edge_mask_apply && right_edge_mask_code == 4'hF
      && logic_function_select_ff == 4'hF
      |=> logic_word == 16'hFFFF)
    else $error("right code fifteen did not enable every bit");

  AST_LEFT_ONE: assert property (!line_draw_sel && left_edge_mask_apply
      && !right_edge_mask_apply && left_edge_mask_code == 4'h1
      && logic_function_select_ff == 4'hF
      |=> logic_word == ($past(dst_slave_ff) | 16'hFFFE))
    else $error("left code one did not protect bit zero only");

  AST_BOTH_MASKS: assert property (!line_draw_sel && left_edge_mask_apply
      && right_edge_mask_apply && left_edge_mask_code == 4'h8
      && right_edge_mask_code == 4'h7
      |=> logic_word == $past(dst_slave_ff))
    else $error("disjoint masks let a bit change");

endmodule
`default_nettype wire

// >>> bench/gfx_ctrl_model.sv
// controller model for the block-transfer front end: data port, load strobes, phases
// assumes the bench calls its tasks; every change lands on a ref_clk falling edge
`timescale 1ns/10ps
`default_nettype none
module gfx_ctrl_model
  import bitblt_pkg::*;
(
  input wire logic ref_clk,                   // system clock
  output var word_t data_in,                  // data port
  output var logic control_load_strobe_n,     // control word load, active low
  output var logic function_load_strobe_n,    // function word load, active low
  output var logic input_latch_strobe_n,      // master latch enable, active low
  output var logic source_dest_steer,         // 1 source, 0 destination
  output var logic phase_one_clock,           // first phase
  output var logic phase_two_clock            // second phase
);
  initial begin
    data_in = 16'hFFFF;
    control_load_strobe_n = 1'b1;
    function_load_strobe_n = 1'b1;
    input_latch_strobe_n = 1'b1;
    source_dest_steer = 1'b0;
    phase_one_clock = 1'b0;
    phase_two_clock = 1'b0;
  end
  task automatic write_reg(input logic is_ctl, input word_t v);
    @(negedge ref_clk);
    data_in = v;
    control_load_strobe_n = ~is_ctl;
    function_load_strobe_n = is_ctl;
    @(negedge ref_clk);
    control_load_strobe_n = 1'b1;
    function_load_strobe_n = 1'b1;
    @(negedge ref_clk);
    // a released port must not keep looking valid
    data_in = ~v;
  endtask
  // one word fetch through the input latch
  task automatic fetch(input word_t w, input logic steer, input logic latch);
    @(negedge ref_clk);
    data_in = w;
    input_latch_strobe_n = ~latch;
    source_dest_steer = steer;
    phase_two_clock = 1'b1;
    @(negedge ref_clk);
    phase_two_clock = 1'b0;
    @(negedge ref_clk);
    input_latch_strobe_n = 1'b1;
    data_in = ~w;
    phase_one_clock = 1'b1;
    @(negedge ref_clk);
    phase_one_clock = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the shift, mask and logic front end
// assumes the controller model drives the port side; bench drives mode, masks, fifo word
`timescale 1ns/10ps
`default_nettype none
module tb;
  import bitblt_pkg::*;
  logic ref_clk, nrst, line_draw_sel, left_edge_mask_apply, right_edge_mask_apply;
  word_t fifo_word, shift_word, logic_word, src, pipe, dst, last_lw;
  wire word_t data_in;
  wire logic cl_n, fl_n, il_n, steer, ph1, ph2;
  logic [12:0] ctl;
  code_t fn;
  int n_fail, tests_run, cycles;
  bitblt_shift_mask_logic #(.DATA_W(16)) i_bitblt_shift_mask_logic (.ref_clk(ref_clk),
    .nrst(nrst), .data_in(data_in), .control_load_strobe_n(cl_n),
    .function_load_strobe_n(fl_n), .input_latch_strobe_n(il_n), .source_dest_steer(steer),
    .phase_one_clock(ph1), .phase_two_clock(ph2), .line_draw_sel(line_draw_sel),
    .left_edge_mask_apply(left_edge_mask_apply), .right_edge_mask_apply(right_edge_mask_apply),
    .fifo_word(fifo_word), .shift_word(shift_word), .logic_word(logic_word));
  gfx_ctrl_model i_gfx_ctrl_model (.ref_clk(ref_clk), .data_in(data_in),
    .control_load_strobe_n(cl_n), .function_load_strobe_n(fl_n), .input_latch_strobe_n(il_n),
    .source_dest_steer(steer), .phase_one_clock(ph1), .phase_two_clock(ph2));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input word_t exp, input word_t got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic load_ctl(input logic [12:0] v);
    // upper port bits set to prove they are ignored
    i_gfx_ctrl_model.write_reg(1'b1, {3'h7, v});
    if (line_draw_sel == 1'b0)
      ctl = v;
  endtask
  task automatic load_fn(input code_t f);
    i_gfx_ctrl_model.write_reg(1'b0, {12'hFA5, f});
    fn = f;
  endtask
  task automatic fetch(input word_t w, input logic to_src, input logic latch);
    i_gfx_ctrl_model.fetch(w, to_src, latch);
    pipe = src;
    if (latch && to_src)
      src = w;
    if (latch && !to_src)
      dst = w;
  endtask
  task automatic check_outputs();
    word_t a, b, r, en;
    logic [31:0] cat;
    repeat (3) @(negedge ref_clk);
    a = ctl[12] ? src : pipe;
    b = ctl[12] ? pipe : src;
    cat = {b, a} >> ctl[11:8];
    check("shift_word", cat[15:0], shift_word);
    en = (left_edge_mask_apply ? word_t'(16'hFFFF << ctl[7:4]) : 16'hFFFF)
      & (right_edge_mask_apply ? word_t'(16'hFFFF >> (4'hF - ctl[3:0])) : 16'hFFFF);
    r = ({16{fn[3]}} & ~fifo_word & ~dst) | ({16{fn[2]}} & ~fifo_word & dst)
      | ({16{fn[1]}} & fifo_word & ~dst) | ({16{fn[0]}} & fifo_word & dst);
    if (line_draw_sel == 1'b0)
      last_lw = (r & en) | (dst & ~en);
    check("logic_word", last_lw, logic_word);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_shift();
    fetch(16'h1234, 1'b1, 1'b1);
    fetch(16'hC3A5, 1'b1, 1'b1);
    for (int i = 0; i < 32; i++) begin
      load_ctl({i[0], i[4:1], 8'h00});
      check_outputs();
    end
    fetch(16'h0F0F, 1'b1, 1'b0);
    check_outputs();
    fetch(16'h3333, 1'b0, 1'b1);
    check_outputs();
  endtask
  task automatic t_line_draw();
    line_draw_sel = 1'b1;
    fifo_word = 16'h8421;
    load_ctl(13'h0F00);
    check_outputs();
    line_draw_sel = 1'b0;
  endtask
  task automatic t_logic();
    fifo_word = 16'h0F0F;
    for (int f = 0; f < 16; f++) begin
      load_fn(f[3:0]);
      check_outputs();
    end
  endtask
  task automatic t_masks();
    load_fn(4'hF);
    for (int n = 0; n < 16; n++) begin
      load_ctl({5'h00, n[3:0], 4'hF - n[3:0]});
      for (int m = 0; m < 4; m++) begin
        left_edge_mask_apply = m[0];
        right_edge_mask_apply = m[1];
        check_outputs();
      end
    end
  endtask
  task automatic t_reset();
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("shift_word", 16'h0000, shift_word);
    check("logic_word", 16'h0000, logic_word);
    nrst = 1'b1;
    {src, pipe, dst, last_lw} = 64'h0;
    load_fn(4'h6);
    load_ctl(13'h1B2D);
    fetch(16'hA55A, 1'b1, 1'b1);
    check_outputs();
  endtask
  initial begin
    nrst = 1'b0;
    line_draw_sel = 1'b0;
    left_edge_mask_apply = 1'b0;
    right_edge_mask_apply = 1'b0;
    fifo_word = 16'h0000;
    {src, pipe, dst, last_lw} = 64'h0;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    // registers are loaded before any transfer
    load_ctl(13'h0000);
    load_fn(4'h3);
    t_shift();
    t_line_draw();
    t_logic();
    t_masks();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
